/* File: core/srsr_pkg.sv */
// Package with status byte, operation event and command constants for the service-request block.
package srsr_pkg;
   // ==========================================
   // Operation event bit positions
   localparam int OP_ALARMING_BIT = 0;
   localparam int OP_OVERLOAD_BIT = 1;
   localparam int OP_RAMP_TWO_BIT = 2;
   localparam int OP_RAMP_ONE_BIT = 3;
   localparam int OP_NEW_READING_BIT = 4;
   localparam int OP_AUTOTUNE_BIT = 5;
   localparam int OP_CAL_ERROR_BIT = 6;
   localparam int OP_PROC_COMM_BIT = 7;
   // ==========================================
   // Status byte and standard event bit positions
   localparam int SB_MAV_BIT = 4;
   localparam int SB_ESB_BIT = 5;
   localparam int SB_MSS_BIT = 6;
   localparam int SB_OSB_BIT = 7;
   localparam int STD_OPC_BIT = 0;
   // ==========================================
   // Reset values
   localparam logic [7:0] OP_EVENT_RESET = 8'h00;
   localparam logic [7:0] OP_ENABLE_RESET = 8'h00;
   localparam logic [7:0] SR_ENABLE_RESET = 8'h00;
   // ==========================================
   // Command codes
   typedef enum logic [2:0] {
      SRSR_CMD_NONE = 3'h0,
      SRSR_CMD_OP_ENABLE_WRITE = 3'h1,
      SRSR_CMD_OP_ENABLE_READ = 3'h2,
      SRSR_CMD_OP_EVENT_READ_CLEAR = 3'h3,
      SRSR_CMD_OP_CONDITION_READ = 3'h4,
      SRSR_CMD_SR_ENABLE_WRITE = 3'h5,
      SRSR_CMD_SR_ENABLE_READ = 3'h6,
      SRSR_CMD_STATUS_BYTE_READ = 3'h7
   } srsr_cmd_e;
   // ==========================================
   // Completion unit states
   typedef enum logic [2:0] {
      SRSR_OPC_IDLE = 3'b001,
      SRSR_OPC_WAIT_SET = 3'b010,
      SRSR_OPC_WAIT_QUERY = 3'b100
   } srsr_opc_state_e;
endpackage

/* File: core/srsr_sync.sv */
// Three-stage pin synchroniser with agreement check on the last two stages.
`timescale 1ns/1ps
`default_nettype none
module srsr_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // A bit changes only once the second and third stages agree.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               sync_out[i] <= 1'b0;
            end else if (stage2_reg[i] == stage3_reg[i]) begin
               sync_out[i] <= stage3_reg[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* File: core/srsr_core.sv */
// Status reporting and service-request block: operation events, status byte and completion.
// Functional notes
// - Processor communication failure sets operation bit 7.
// - Missing or corrupt calibration sets bit 6.
// - Autotune inactive sets operation bit 5.
// - Each new sensor reading sets bit 4.
// - Ramp done sets bit 3 or bit 2.
// - Sensor overload sets operation bit 1.
// - Visible alarm sets operation bit 0.
// - Event read clears; condition read does not.
// - Operation summary is masked event OR; enable readable.
// - Summary bits follow sources, never latch.
// - Message available follows nonempty output buffer.
// - Status bit 7 shows enabled operation events.
// - Status bit 5 shows enabled standard events.
// - Master summary is OR of enabled summaries.
// - Enabled summary rise sets request and line.
// - Serial poll answers byte, clears request only.
// - No new request until source register clears.
// - Master summary stays until sources or enables clear.
// - Status query equals poll except bit 6 (master summary, not request), clears nothing.
// - Completion command sets standard bit 0 later.
// - Completion query queues 1 after operations finish.
// - Only enable registers are user writable.
// - Query responses carry plain binary weighted value.
`timescale 1ns/1ps
`default_nettype none
module srsr_core
   import srsr_pkg::*;
#(
   parameter int OP_WIDTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Instrument condition inputs (asynchronous pins)
   input wire logic proc_comm_error,
   input wire logic calibration_error,
   input wire logic autotune_active,
   input wire logic new_reading,
   input wire logic loop_one_ramp_done,
   input wire logic loop_two_ramp_done,
   input wire logic sensor_overload,
   input wire logic input_alarm,
   input wire logic alarm_visible,
   // Standard event summary and output buffer state (same clock)
   input wire logic std_event_summary,
   input wire logic output_buffer_nonempty,
   // Pending device operations (same clock)
   input wire logic operations_pending,
   // Command port
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [7:0] cmd_data,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   // Completion commands
   input wire logic opc_command,
   input wire logic opc_query,
   output logic opc_event_set,
   output logic opc_query_answer,
   output logic bus_hold,
   // Bus service request and serial poll
   input wire logic serial_poll,
   output logic service_request,
   output logic poll_valid,
   output logic [7:0] poll_data,
   // Live status byte
   output logic [7:0] status_summary_byte
);
   // ==========================================
   // Elaboration check
   if (OP_WIDTH != 8) begin : g_width_check
      $error("srsr_core supports only an 8-bit operation register");
   end

   // ==========================================
   // Condition synchronisation
   logic [7:0] cond_raw;
   logic [7:0] cond_sync;
   logic [7:0] cond_prev_reg;
   logic [7:0] condition_now;
   logic [7:0] event_set;

   assign cond_raw[OP_PROC_COMM_BIT] = proc_comm_error;
   assign cond_raw[OP_CAL_ERROR_BIT] = calibration_error;
   assign cond_raw[OP_AUTOTUNE_BIT] = ~autotune_active;
   assign cond_raw[OP_NEW_READING_BIT] = new_reading;
   assign cond_raw[OP_RAMP_ONE_BIT] = loop_one_ramp_done;
   assign cond_raw[OP_RAMP_TWO_BIT] = loop_two_ramp_done;
   assign cond_raw[OP_OVERLOAD_BIT] = sensor_overload;
   assign cond_raw[OP_ALARMING_BIT] = input_alarm & alarm_visible;

   srsr_sync #(
      .WIDTH(8)
   ) u_cond_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(cond_raw),
      .sync_out(cond_sync)
   );

   assign condition_now = cond_sync;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cond_prev_reg <= 8'h00;
      end else begin
         cond_prev_reg <= cond_sync;
      end
   end

   // An event latches on the rising edge of its condition.
   assign event_set = cond_sync & ~cond_prev_reg;

   // ==========================================
   // Command decode
   function automatic logic is_cmd(input logic v, input logic [2:0] c, input srsr_cmd_e k);
      is_cmd = v && (c == 3'(k));
   endfunction

   logic op_event_clear;
   logic op_enable_wr;
   logic sr_enable_wr;
   assign op_event_clear = is_cmd(cmd_valid, cmd_code, SRSR_CMD_OP_EVENT_READ_CLEAR);
   assign op_enable_wr = is_cmd(cmd_valid, cmd_code, SRSR_CMD_OP_ENABLE_WRITE);
   assign sr_enable_wr = is_cmd(cmd_valid, cmd_code, SRSR_CMD_SR_ENABLE_WRITE);

   // ==========================================
   // Operation event and enable registers
   logic [7:0] operation_event_latch_reg;
   logic [7:0] operation_enable_reg;
   logic [7:0] sr_enable_reg;

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         operation_event_latch_reg <= OP_EVENT_RESET;
      end else if (op_event_clear) begin
         operation_event_latch_reg <= event_set;
      end else begin
         operation_event_latch_reg <= operation_event_latch_reg | event_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         operation_enable_reg <= OP_ENABLE_RESET;
      end else if (op_enable_wr) begin
         operation_enable_reg <= cmd_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sr_enable_reg <= SR_ENABLE_RESET;
      end else if (sr_enable_wr) begin
         sr_enable_reg <= cmd_data;
      end
   end

   // ==========================================
   // Summary bits and master summary
   logic [7:0] event_after;
   logic operation_summary;
   logic [7:0] summary_vec;
   logic [7:0] enabled_summary;
   logic master_summary;
   logic [7:0] status_byte_now;

   // The summaries look at the register state the current command leaves behind.
   assign event_after = op_event_clear ? event_set : (operation_event_latch_reg | event_set);
   logic [7:0] op_enable_now;
   assign op_enable_now = op_enable_wr ? cmd_data : operation_enable_reg;
   assign operation_summary = |(event_after & op_enable_now);

   always_comb begin
      summary_vec = 8'h00;
      summary_vec[SB_OSB_BIT] = operation_summary;
      summary_vec[SB_ESB_BIT] = std_event_summary;
      summary_vec[SB_MAV_BIT] = output_buffer_nonempty;
   end

   assign enabled_summary = summary_vec & (sr_enable_wr ? cmd_data : sr_enable_reg);
   assign master_summary = |enabled_summary;

   always_comb begin
      status_byte_now = summary_vec;
      status_byte_now[SB_MSS_BIT] = master_summary;
   end

   // ==========================================
   // Service request
   logic [7:0] enabled_prev_reg;
   logic [7:0] armed_reg;
   logic [7:0] rise;
   logic rqs_reg;

   assign rise = enabled_summary & ~enabled_prev_reg & armed_reg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         enabled_prev_reg <= 8'h00;
      end else begin
         enabled_prev_reg <= enabled_summary;
      end
   end

   // A polled summary bit is disarmed until its source drops to zero.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         armed_reg <= 8'hff;
      end else if (serial_poll && rqs_reg) begin
         armed_reg <= ~enabled_summary;
      end else begin
         armed_reg <= armed_reg | ~summary_vec;
      end
   end

   // A rise in the poll cycle still raises a fresh request.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rqs_reg <= 1'b0;
      end else if (|rise) begin
         rqs_reg <= 1'b1;
      end else if (serial_poll) begin
         rqs_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         service_request <= 1'b0;
      end else begin
         service_request <= (|rise) | (rqs_reg & ~serial_poll);
      end
   end

   // ==========================================
   // Serial poll answer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         poll_valid <= 1'b0;
         poll_data <= 8'h00;
      end else begin
         poll_valid <= serial_poll;
         if (serial_poll) begin
            poll_data <= {summary_vec[7], rqs_reg, summary_vec[5:0]};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         status_summary_byte <= 8'h00;
      end else begin
         status_summary_byte <= status_byte_now;
      end
   end

   // ==========================================
   // Command responses
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         if (cmd_valid) begin
            unique case (cmd_code)
               3'(SRSR_CMD_OP_ENABLE_READ): begin
                  rsp_valid <= 1'b1;
                  rsp_data <= operation_enable_reg;
               end
               3'(SRSR_CMD_OP_EVENT_READ_CLEAR): begin
                  rsp_valid <= 1'b1;
                  rsp_data <= operation_event_latch_reg;
               end
               3'(SRSR_CMD_OP_CONDITION_READ): begin
                  rsp_valid <= 1'b1;
                  rsp_data <= condition_now;
               end
               3'(SRSR_CMD_SR_ENABLE_READ): begin
                  rsp_valid <= 1'b1;
                  rsp_data <= sr_enable_reg;
               end
               3'(SRSR_CMD_STATUS_BYTE_READ): begin
                  rsp_valid <= 1'b1;
                  rsp_data <= status_byte_now;
               end
               default: begin
                  rsp_valid <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Operation completion
   srsr_opc_state_e opc_state_reg;
   logic opc_armed_reg;

   // The set request waits in the background so other commands stay accepted.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         opc_armed_reg <= 1'b0;
         opc_event_set <= 1'b0;
      end else begin
         opc_event_set <= 1'b0;
         if (opc_armed_reg && !operations_pending) begin
            opc_armed_reg <= 1'b0;
            opc_event_set <= 1'b1;
         end else if (opc_command) begin
            opc_armed_reg <= 1'b1;
         end
      end
   end

   // The query holds the bus; commands during the hold are the controller's hazard.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         opc_state_reg <= SRSR_OPC_IDLE;
         opc_query_answer <= 1'b0;
         bus_hold <= 1'b0;
      end else begin
         opc_query_answer <= 1'b0;
         unique case (opc_state_reg)
            SRSR_OPC_IDLE: begin
               if (opc_query) begin
                  opc_state_reg <= SRSR_OPC_WAIT_QUERY;
                  bus_hold <= 1'b1;
               end
            end
            SRSR_OPC_WAIT_QUERY: begin
               if (!operations_pending) begin
                  opc_state_reg <= SRSR_OPC_IDLE;
                  bus_hold <= 1'b0;
                  opc_query_answer <= 1'b1;
               end
            end
            default: begin
               opc_state_reg <= SRSR_OPC_IDLE;
               bus_hold <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: verification/srsr_core_sva.sv */
// Concurrent checks on the ports of the service-request block.
`timescale 1ns/1ps
`default_nettype none
module srsr_core_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic rsp_valid,
   input wire logic std_event_summary,
   input wire logic output_buffer_nonempty,
   input wire logic operations_pending,
   input wire logic opc_event_set,
   input wire logic opc_query_answer,
   input wire logic bus_hold,
   input wire logic serial_poll,
   input wire logic service_request,
   input wire logic poll_valid,
   input wire logic [7:0] poll_data,
   input wire logic [7:0] status_summary_byte
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Assertions
   AST_POLL_ANSWER: assert property (serial_poll |=> poll_valid)
      else $error("serial poll not answered");
   AST_POLL_DROP: assert property (poll_valid |-> !service_request)
      else $error("request still up after poll");
   AST_POLL_RQS: assert property (poll_valid |-> poll_data[6] == $past(service_request))
      else $error("poll byte bit 6 differs from request");
   AST_RSP_CAUSE: assert property (rsp_valid |-> $past(cmd_valid))
      else $error("response without command");
   AST_READ_ANSWER: assert property (cmd_valid && !(cmd_code inside {3'h0, 3'h1, 3'h5})
      |=> rsp_valid)
      else $error("read not answered");
   AST_MAV: assert property (!$past(sys_rst) |->
      status_summary_byte[4] == $past(output_buffer_nonempty))
      else $error("message bit wrong");
   AST_ESB: assert property (!$past(sys_rst) |->
      status_summary_byte[5] == $past(std_event_summary))
      else $error("standard summary bit wrong");
   AST_MSS_SRC: assert property (status_summary_byte[6] |->
      |{status_summary_byte[7], status_summary_byte[5:4]})
      else $error("master summary without source");
   AST_POLL_BYTE: assert property (poll_valid |->
      {poll_data[7], poll_data[5:0]} == {status_summary_byte[7], status_summary_byte[5:0]})
      else $error("poll byte differs from status byte");
   AST_SRQ_RISE: assert property ($rose(service_request) |-> status_summary_byte[6])
      else $error("request without master summary");
   AST_OPC_SET: assert property (opc_event_set |-> !$past(operations_pending))
      else $error("completion set while busy");
   AST_OPC_ANS: assert property (opc_query_answer |-> $past(bus_hold) && !bus_hold)
      else $error("query answer without hold");
   AST_HOLD: assert property (bus_hold && operations_pending |=> bus_hold)
      else $error("hold released while busy");
   // ==========================================
   // Coverage
   COV_POLL: cover property (poll_valid && poll_data[6]);
   COV_SET: cover property (opc_event_set);
   COV_ANS: cover property (opc_query_answer);
endmodule
bind srsr_core srsr_core_chk chk_u (.*);
`default_nettype wire

/* File: verification/srsr_ctrl_model.sv */
// Bus controller model that answers service requests with serial polls.
`timescale 1ns/1ps
`default_nettype none
module srsr_ctrl_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Test control
   input wire logic auto_poll,
   input wire logic [3:0] poll_wait,
   // Device side
   input wire logic service_request,
   input wire logic poll_valid,
   input wire logic [7:0] poll_data,
   output logic serial_poll,
   // Observations
   output logic [7:0] last_poll,
   output logic [7:0] poll_cnt
);
   logic [3:0] wait_reg;
   // Polls once after the request has stood for poll_wait cycles.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !service_request || serial_poll) begin
         wait_reg <= 4'h0;
         serial_poll <= 1'b0;
      end else if (auto_poll && wait_reg == poll_wait) begin
         serial_poll <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         poll_cnt <= 8'h00;
         last_poll <= 8'h00;
      end else if (poll_valid) begin
         poll_cnt <= poll_cnt + 8'h01;
         last_poll <= poll_data;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the service-request block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] pins = 8'h00;
   logic vis = 1'b0;
   logic std_event_summary = 1'b0;
   logic output_buffer_nonempty = 1'b0;
   logic operations_pending = 1'b0;
   logic cmd_valid = 1'b0;
   logic [2:0] cmd_code = 3'h0;
   logic [7:0] cmd_data = 8'h00;
   logic opc_command = 1'b0;
   logic opc_query = 1'b0;
   logic auto_poll = 1'b0;
   logic rsp_valid, opc_event_set, opc_query_answer, bus_hold, serial_poll;
   logic service_request, poll_valid;
   logic [7:0] rsp_data, poll_data, status_summary_byte, last_poll, poll_cnt;
   logic [7:0] n_set = 8'h00;
   logic [7:0] n_ans = 8'h00;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   srsr_core dut_u (.sys_clk, .sys_rst, .proc_comm_error(pins[7]),
      .calibration_error(pins[6]), .autotune_active(~pins[5]), .new_reading(pins[4]),
      .loop_one_ramp_done(pins[3]), .loop_two_ramp_done(pins[2]),
      .sensor_overload(pins[1]), .input_alarm(pins[0]), .alarm_visible(vis),
      .std_event_summary, .output_buffer_nonempty, .operations_pending, .cmd_valid,
      .cmd_code, .cmd_data, .rsp_valid, .rsp_data, .opc_command, .opc_query,
      .opc_event_set, .opc_query_answer, .bus_hold, .serial_poll, .service_request,
      .poll_valid, .poll_data, .status_summary_byte);
   srsr_ctrl_model ctrl_u (.sys_clk, .sys_rst, .auto_poll, .poll_wait(4'h2),
      .service_request, .poll_valid, .poll_data, .serial_poll, .last_poll, .poll_cnt);
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      n_set <= n_set + {7'h00, opc_event_set};
      n_ans <= n_ans + {7'h00, opc_query_answer};
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [2:0] c, input logic [7:0] d);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_data = d;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask
   // Reads a register; a missing response turns into a mismatch.
   task automatic rd(input logic [2:0] c, input logic [7:0] exp);
      wr(c, 8'h00);
      chk(rsp_valid ? rsp_data : ~exp, exp);
   endtask
   initial begin
      tick(5);
      sys_rst = 1'b0;
      rd(3'h2, 8'h00);
      rd(3'h6, 8'h00);
      rd(3'h3, 8'h00);
      rd(3'h7, 8'h00);
      pins[0] = 1'b1;
      tick(8);
      rd(3'h4, 8'h00);
      pins[0] = 1'b0;
      vis = 1'b1;
      tick(8);
      for (int i = 0; i < 8; i++) begin
         pins[i] = 1'b1;
         tick(8);
         rd(3'h4, 8'(1 << i));
         rd(3'h4, 8'(1 << i));
         rd(3'h3, 8'(1 << i));
         rd(3'h3, 8'h00);
         pins[i] = 1'b0;
         tick(8);
         rd(3'h4, 8'h00);
      end
      wr(3'h1, 8'h10);
      rd(3'h2, 8'h10);
      wr(3'h5, 8'h80);
      rd(3'h6, 8'h80);
      auto_poll = 1'b1;
      pins[4] = 1'b1;
      tick(10);
      rd(3'h7, 8'hc0);
      chk(status_summary_byte, 8'hc0);
      chk(poll_cnt, 8'h01);
      chk(last_poll, 8'hc0);
      chk({7'h00, service_request}, 8'h00);
      pins[4] = 1'b0;
      tick(8);
      pins[4] = 1'b1;
      tick(10);
      chk(poll_cnt, 8'h01);
      wr(3'h5, 8'h00);
      wr(3'h5, 8'h80);
      tick(8);
      chk(poll_cnt, 8'h01);
      chk({7'h00, service_request}, 8'h00);
      wr(3'h5, 8'h00);
      rd(3'h7, 8'h80);
      rd(3'h3, 8'h10);
      rd(3'h7, 8'h00);
      pins[4] = 1'b0;
      pins[1] = 1'b1;
      tick(8);
      rd(3'h7, 8'h00);
      rd(3'h3, 8'h02);
      pins[1] = 1'b0;
      auto_poll = 1'b0;
      wr(3'h5, 8'h30);
      output_buffer_nonempty = 1'b1;
      std_event_summary = 1'b1;
      tick(3);
      rd(3'h7, 8'h70);
      chk({7'h00, service_request}, 8'h01);
      output_buffer_nonempty = 1'b0;
      std_event_summary = 1'b0;
      tick(3);
      rd(3'h7, 8'h00);
      operations_pending = 1'b1;
      opc_command = 1'b1;
      tick(1);
      opc_command = 1'b0;
      tick(6);
      rd(3'h2, 8'h10);
      chk(n_set, 8'h00);
      operations_pending = 1'b0;
      tick(6);
      chk(n_set, 8'h01);
      operations_pending = 1'b1;
      opc_query = 1'b1;
      tick(1);
      opc_query = 1'b0;
      // No command is sent while the query waits.
      tick(6);
      chk({7'h00, bus_hold}, 8'h01);
      chk(n_ans, 8'h00);
      operations_pending = 1'b0;
      tick(6);
      chk(n_ans, 8'h01);
      chk({7'h00, bus_hold}, 8'h00);
      chk(n_set, 8'h01);
      report_and_stop();
   end
endmodule
`default_nettype wire
